/* hdl/gpio_misc_params.svh */
`ifndef GPIO_MISC_PARAMS_SVH
`define GPIO_MISC_PARAMS_SVH

`define OFS_GENERAL_IO_PINS 8'h14
`define OFS_MISC_REFERENCE_ROUTING 8'h15
`define OFS_MISC_RESERVED_TWO 8'h16
`define OFS_CONVERSION_MODE_CONFIG 8'h17

`define POS_PIN_DATA_LSB 4
`define POS_PIN_DIRECTION_LSB 0
`define POS_SHARED_REFERENCE_SWITCH 5
`define POS_SINGLE_SHOT 3
`define POS_ELECTRODE_COMPARATOR_ENABLE 1

`define RST_PIN_DIRECTION_BITS 4'hF
`define RST_PIN_DATA_BITS 4'h0
`define RST_REG_BYTE 8'h00

`define RESP_TAKES_PINS_BIT 0
`define RESP_TAKEN_PIN_MASK 4'hE

`define SYNC_STAGES 2

`endif

/* hdl/gpio_misc_pkg.sv */
`default_nettype none

package gpio_misc_pkg;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [3:0] pin_direction_bits;
      logic [3:0] pin_data_bits;
      logic shared_reference_switch;
      logic single_shot;
      logic electrode_comparator_enable;
      logic [7:0] rd_data;
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
   } regs_t;

endpackage

`default_nettype wire

/* hdl/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_sync
#(
   parameter int WIDTH = 4
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // Kept local because its width follows the parameter.
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   // The first stage feeds only the second, so a metastable level never reaches a reader.
   always_comb
   begin
      s_nxt.meta = async_in;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign sync_out = s_r.stable;

endmodule

`default_nettype wire

/* hdl/gpio_misc_config_regs.sv */
// Behaviour
// RULE1 - data bit reads return live pin level
// RULE2 - output pin drives written data bit
// RULE3 - data write ignored on input pins
// RULE4 - direction bit zero output, one input
// RULE5 - reset: directions all one, data zero
// RULE6 - respiration modes take pins from I/O
// RULE7 - respiration 01 or 11 takes pins two-four
// RULE8 - bit five closes shared reference switches
// RULE9 - host writes zero to reserved bits
// RULE10 - bit three selects single-shot conversion
// RULE11 - bit one enables lead-off comparators
// RULE12 - pin levels synchronised before readback
`timescale 1ns/10ps
`default_nettype none
`include "gpio_misc_params.svh"

module gpio_misc_config_regs
#(
   parameter int PINS = 4
)
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire gpio_misc_pkg::reg_req_t req,
   output logic [7:0] rd_data,
   input wire logic [1:0] respiration_select,
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe,
   output logic shared_reference_switch,
   output logic single_shot,
   output logic electrode_comparator_enable
);
   import gpio_misc_pkg::*;

   regs_t s_r;
   regs_t s_nxt;
   logic [PINS-1:0] pin_sync_w;

   // Pins the respiration circuit has claimed; their enables drop at the clock edge after the claim.
   function automatic logic [3:0] taken_mask(input logic [1:0] resp);
      taken_mask = resp[`RESP_TAKES_PINS_BIT] ? `RESP_TAKEN_PIN_MASK : 4'h0; // RULE6 RULE7
   endfunction

   function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   pin_sync #(.WIDTH(PINS)) u_sync
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .async_in(pin_in),
      .sync_out(pin_sync_w)
   );

   always_comb
   begin
      s_nxt = s_r;
      if (req.wr)
      begin
         if (hit(req, `OFS_GENERAL_IO_PINS))
         begin
            // Data bits only latch on pins currently set as outputs.
            for (int i = 0; i < PINS; i++)
            begin
               if (!s_r.pin_direction_bits[i]) // RULE3
               begin
                  s_nxt.pin_data_bits[i] = req.wdata[`POS_PIN_DATA_LSB + i]; // RULE2
               end
            end
            s_nxt.pin_direction_bits = req.wdata[`POS_PIN_DIRECTION_LSB +: 4]; // RULE4
         end
         if (hit(req, `OFS_MISC_REFERENCE_ROUTING))
         begin
            s_nxt.shared_reference_switch = req.wdata[`POS_SHARED_REFERENCE_SWITCH]; // RULE8
         end
         if (hit(req, `OFS_CONVERSION_MODE_CONFIG))
         begin
            s_nxt.single_shot = req.wdata[`POS_SINGLE_SHOT]; // RULE10
            s_nxt.electrode_comparator_enable =
               req.wdata[`POS_ELECTRODE_COMPARATOR_ENABLE]; // RULE11
         end
      end
      // Reserved bits are not stored, so they read zero whatever the host wrote.
      if (req.rd)
      begin
         case (req.addr)
            `OFS_GENERAL_IO_PINS:
               s_nxt.rd_data = {pin_sync_w, s_r.pin_direction_bits}; // RULE1 RULE12
            `OFS_MISC_REFERENCE_ROUTING:
               s_nxt.rd_data = 8'(s_r.shared_reference_switch)
                  << `POS_SHARED_REFERENCE_SWITCH;
            `OFS_CONVERSION_MODE_CONFIG:
               s_nxt.rd_data = (8'(s_r.single_shot) << `POS_SINGLE_SHOT)
                  | (8'(s_r.electrode_comparator_enable) << `POS_ELECTRODE_COMPARATOR_ENABLE);
            default:
               s_nxt.rd_data = `RST_REG_BYTE; // RULE9
         endcase
      end
      // Enables follow the next direction value, so a pin is released in the same cycle
      // that its direction bit turns it into an input.
      s_nxt.pin_out = s_nxt.pin_data_bits;
      s_nxt.pin_oe = ~s_nxt.pin_direction_bits & ~taken_mask(respiration_select); // RULE4 RULE6
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // Enables start low, so no pin is driven before the host asks for it.
         s_r.pin_direction_bits <= `RST_PIN_DIRECTION_BITS; // RULE5
         s_r.pin_data_bits <= `RST_PIN_DATA_BITS; // RULE5
         s_r.shared_reference_switch <= 1'b0;
         s_r.single_shot <= 1'b0;
         s_r.electrode_comparator_enable <= 1'b0;
         s_r.rd_data <= `RST_REG_BYTE;
         s_r.pin_out <= `RST_PIN_DATA_BITS;
         s_r.pin_oe <= 4'h0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign rd_data = s_r.rd_data;
   assign pin_out = s_r.pin_out;
   assign pin_oe = s_r.pin_oe;
   assign shared_reference_switch = s_r.shared_reference_switch;
   assign single_shot = s_r.single_shot;
   assign electrode_comparator_enable = s_r.electrode_comparator_enable;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   a_pin_readback: assert property ( // RULE1
      req.rd && req.addr == `OFS_GENERAL_IO_PINS |=> rd_data[7:4] == $past(pin_in, 3))
      else $error("pin readback does not match synchronised pin level");

   // Every pin gets its own pair of checks, so a slip on one bit index cannot hide.
   generate
      for (genvar p = 0; p < PINS; p++)
      begin : g_pin_checks
         a_output_drive: assert property ( // RULE2
            @(posedge sys_clk) disable iff (!arst_n)
            req.wr && req.addr == `OFS_GENERAL_IO_PINS && !s_r.pin_direction_bits[p]
            |=> pin_out[p] == $past(req.wdata[`POS_PIN_DATA_LSB + p]))
            else $error("output pin does not follow written data");

         a_input_hold: assert property ( // RULE3
            @(posedge sys_clk) disable iff (!arst_n)
            s_r.pin_direction_bits[p] |=> $stable(s_r.pin_data_bits[p]))
            else $error("data bit of input pin changed");
      end
   endgenerate

   a_dir_enable: assert property ( // RULE4
      s_r.pin_direction_bits[0] |-> !pin_oe[0])
      else $error("input pin is being driven");

   a_resp_take: assert property ( // RULE7
      respiration_select[0] |=> pin_oe[3:1] == 3'h0)
      else $error("pin driven while respiration owns it");

   a_srb_write: assert property ( // RULE8
      req.wr && req.addr == `OFS_MISC_REFERENCE_ROUTING
      |=> shared_reference_switch == $past(req.wdata[5]))
      else $error("reference switch not updated");

   a_mode_write: assert property ( // RULE10
      req.wr && req.addr == `OFS_CONVERSION_MODE_CONFIG
      |=> single_shot == $past(req.wdata[3]) ##1 $stable(single_shot) || $past(req.wr))
      else $error("conversion mode not updated");

   a_comp_write: assert property ( // RULE11
      req.wr && req.addr == `OFS_CONVERSION_MODE_CONFIG
      |=> electrode_comparator_enable == $past(req.wdata[1]))
      else $error("comparator enable not updated");

   a_reserved_zero: assert property ( // RULE9
      req.rd && req.addr == `OFS_MISC_RESERVED_TWO |=> rd_data == 8'h00)
      else $error("reserved register read not zero");

   a_reset_state: assert property ( // RULE5
      $rose(arst_n) |-> s_r.pin_direction_bits == `RST_PIN_DIRECTION_BITS
         && s_r.pin_data_bits == `RST_PIN_DATA_BITS && pin_oe == 4'h0)
      else $error("register state after reset is wrong");

   a_dir_write: assert property ( // RULE4
      req.wr && req.addr == `OFS_GENERAL_IO_PINS
      |=> s_r.pin_direction_bits == $past(req.wdata[`POS_PIN_DIRECTION_LSB +: 4]))
      else $error("direction bits not updated");

   a_resp_free: assert property ( // RULE7
      !respiration_select[`RESP_TAKES_PINS_BIT] |=> pin_oe == ~s_r.pin_direction_bits)
      else $error("free pin not driven as its direction asks");

   a_route_reserved: assert property ( // RULE9
      req.rd && req.addr == `OFS_MISC_REFERENCE_ROUTING
      |=> rd_data[7:6] == 2'h0 && rd_data[4:0] == 5'h00)
      else $error("reserved bits of routing register not zero");

   a_mode_reserved: assert property ( // RULE9
      req.rd && req.addr == `OFS_CONVERSION_MODE_CONFIG
      |=> rd_data[7:4] == 4'h0 && rd_data[2] == 1'b0 && rd_data[0] == 1'b0)
      else $error("reserved bits of mode register not zero");

   a_unmapped_zero: assert property ( // RULE9
      req.rd && !(req.addr inside {`OFS_GENERAL_IO_PINS, `OFS_MISC_REFERENCE_ROUTING,
         `OFS_CONVERSION_MODE_CONFIG}) |=> rd_data == 8'h00)
      else $error("read of unmapped address not zero");

   a_route_hold: assert property ( // RULE8
      !(req.wr && req.addr == `OFS_MISC_REFERENCE_ROUTING)
      |=> $stable(shared_reference_switch))
      else $error("reference switch changed without a write");

   // Read data must stand between reads, since the host may fetch it late.
   a_rdata_hold: assert property ( // RULE1
      !req.rd |=> $stable(rd_data))
      else $error("read data changed without a read");

endmodule

`default_nettype wire

/* tb/pin_partner.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_partner
(
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] ext_level,
   output logic [3:0] pin_in
);
   // An undriven pin shows the outside level, never the last driven one.
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

`default_nettype wire

/* tb/gpio_misc_config_regs_test.sv */
`timescale 1ns/10ps
`default_nettype none

module gpio_misc_config_regs_test;
   import gpio_misc_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   reg_req_t req = '0;
   logic [1:0] respiration_select = 2'b00;
   logic [3:0] ext_level = 4'h0;
   logic [7:0] rd_data;
   logic [3:0] pin_in, pin_out, pin_oe;
   logic shared_reference_switch, single_shot, electrode_comparator_enable;
   logic [7:0] exp_q[$];
   logic rd_seen = 1'b0;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   integer seed = 80;
   logic [3:0] prev_level = 4'h0;

   always #5 sys_clk = ~sys_clk;

   gpio_misc_config_regs uut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
      .rd_data(rd_data), .respiration_select(respiration_select), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .shared_reference_switch(shared_reference_switch),
      .single_shot(single_shot), .electrode_comparator_enable(electrode_comparator_enable));
   pin_partner far_side (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .pin_in(pin_in));

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] val);
      @(negedge sys_clk);
      req.wr = wr;
      req.rd = ~wr;
      req.addr = addr;
      req.wdata = wr ? val : 8'h00;
      if (!wr)
         exp_q.push_back(val);
      @(negedge sys_clk);
      req = '0;
   endtask

   always @(posedge sys_clk)
   begin
      rd_seen <= req.rd;
      cycles++;
      if (cycles > 2000)
      begin
         err_count++;
         end_of_test();
      end
   end

   // Read data is looked at half a cycle after the edge that registers it.
   always @(negedge sys_clk)
      if (rd_seen)
         check(rd_data, exp_q.pop_front());

   initial
   begin
      repeat (5) @(posedge sys_clk);
      for (int r = 0; r < 2; r++)
      begin
         @(negedge sys_clk);
         arst_n = 1'b1;
         ext_level = 4'($random(seed));
         repeat (3) @(negedge sys_clk);
         check({pin_out, pin_oe}, 8'h00);
         access(0, 8'h14, {ext_level, 4'hF});
         // A level change just before a read is not yet through the synchroniser.
         prev_level = ext_level;
         ext_level = 4'($random(seed));
         access(0, 8'h14, {prev_level, 4'hF});
         access(0, 8'h15, 8'h00);
         access(0, 8'h16, 8'h00);
         access(0, 8'h17, 8'h00);
         access(1, 8'h30, 8'hFF);
         access(0, 8'h30, 8'h00);
         access(1, 8'h15, 8'h20);
         check({7'h0, shared_reference_switch}, 8'h01);
         access(0, 8'h15, 8'h20);
         for (int v = 0; v < 4; v++)
         begin
            access(1, 8'h17, {4'h0, v[1], 1'b0, v[0], 1'b0});
            check({single_shot, electrode_comparator_enable}, 8'(v));
            access(0, 8'h17, {4'h0, v[1], 1'b0, v[0], 1'b0});
         end
         access(1, 8'h14, 8'h50);
         check({pin_out, pin_oe}, 8'h0F);
         access(1, 8'h14, 8'h50);
         check({pin_out, pin_oe}, 8'h5F);
         repeat (3) @(negedge sys_clk);
         access(0, 8'h14, 8'h50);
         respiration_select = 2'($random(seed)) | 2'b01;
         repeat (4) @(negedge sys_clk);
         check({4'h0, pin_oe}, 8'h01);
         access(0, 8'h14, {ext_level[3:1], 1'b1, 4'h0});
         respiration_select = 2'b10;
         repeat (2) @(negedge sys_clk);
         check({4'h0, pin_oe}, 8'h0F);
         respiration_select = 2'b00;
         // A second reset in mid-run must bring everything back to its start.
         arst_n = 1'b0;
         repeat (2) @(negedge sys_clk);
      end
      end_of_test();
   end
endmodule

`default_nettype wire
